/* File: shared/ssm_cfg.svh */
// constants of the serial memory front end
`ifndef SSM_CFG_SVH
`define SSM_CFG_SVH
// command codes
`define SSM_CMD_SET_WL 8'h06
`define SSM_CMD_CLR_WL 8'h04
`define SSM_CMD_ST_RD 8'h05
`define SSM_CMD_ST_WR 8'h01
`define SSM_CMD_ARR_RD 8'h03
`define SSM_CMD_ARR_WR 8'h02
`define SSM_CMD_SLEEP 8'hB9
`define SSM_CMD_WAKE 8'hAB
// status field positions
`define SSM_ST_LOCK 7
`define SSM_ST_GUARD_HI 3
`define SSM_ST_GUARD_LO 2
`define SSM_ST_WEL 1
// reset values
`define SSM_ST_RESET 8'h00
// pin sample at rest: clock low, deselected, data low, hold and write-protect high
`define SSM_PIN_IDLE 5'h0B
// timing counts
`define SSM_ADDR_BYTES 2'h2
`define SSM_BYTE_LAST 3'h7
`endif

/* File: shared/ssm_pkg.sv */
// types of the serial memory front end
package ssm_pkg;
   // pins from the host, one sample
   typedef struct packed {
      logic sck;
      logic csN;
      logic si;
      logic holdN;
      logic wpN;
   } ssm_pins_t;
   // protocol phase within one chip-select period
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CMD = 3'b001,
      ST_ADDR = 3'b010,
      ST_RDOUT = 3'b011,
      ST_WDATA = 3'b100,
      ST_STWR = 3'b101,
      ST_DONE = 3'b110
   } ssm_state_t;
endpackage

/* File: rtl/ssm_front_end.sv */
// serial peripheral target front end with status register and byte array
`timescale 1ns/1ns
`include "ssm_cfg.svh"
module ssm_front_end #(
   parameter int ADDR_W = 15
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // serial pins from host
   input wire logic spiClk,
   input wire logic chipSelN,
   input wire logic serIn,
   input wire logic holdN,
   input wire logic writeProtN,
   // serial output pin and its enable
   output logic serOutQ,
   output logic serOutEnQ,
   // mode seen at select (1: mode 3) and sleep state
   output logic spiModeQ,
   output logic sleepQ
);
   // three-stage synchroniser and agreed value
   ssm_pkg::ssm_pins_t pinsIn;
   ssm_pkg::ssm_pins_t sync1Q, sync2Q, sync3Q, filtQ, filtD;
   // protocol state
   ssm_pkg::ssm_state_t stateQ;
   logic csActQ; // select seen active, frozen during hold
   logic [2:0] bitCntQ; // bits of current byte
   logic [6:0] shiftQ; // input shift register
   logic [7:0] cmdQ; // command of this period
   logic [1:0] addrCntQ; // address bytes taken
   logic [15:0] addrQ; // full address as shifted in
   logic [7:0] statusQ; // status register
   logic [6:0] outShiftQ; // remaining output bits
   logic [2:0] outCntQ; // output bits sent of current byte
   logic riseSeenQ; // a rising edge happened this period
   // memory array
   logic [7:0] memQ [2**ADDR_W];
   // events
   logic active, riseEv, fallEv, csFallEv, csRiseEv, byteDone;
   logic [7:0] inByte, rdByte;
   logic [ADDR_W-1:0] memAddr;
   logic memWe, stWrOk;

   // protected region test from guard pair
   function automatic logic guarded(input logic [1:0] g, input logic [ADDR_W-1:0] a);
      unique case (g)
         2'b00: guarded = 1'b0;
         2'b01: guarded = &a[ADDR_W-1 -: 2];
         2'b10: guarded = a[ADDR_W-1];
         2'b11: guarded = 1'b1;
      endcase
   endfunction

   assign pinsIn = '{sck: spiClk, csN: chipSelN, si: serIn, holdN: holdN, wpN: writeProtN};

   // a bit changes once second and third stage agree
   always_comb begin
      for (int i = 0; i < $bits(ssm_pkg::ssm_pins_t); i++) begin
         filtD[i] = (sync2Q[i] == sync3Q[i]) ? sync3Q[i] : filtQ[i];
      end
   end

   // synchroniser chain, idle values on reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         // idle pin levels, so no false edge follows reset
         sync1Q <= `SSM_PIN_IDLE;
         sync2Q <= `SSM_PIN_IDLE;
         sync3Q <= `SSM_PIN_IDLE;
         filtQ <= `SSM_PIN_IDLE;
      end else begin
         sync1Q <= pinsIn;
         sync2Q <= sync1Q;
         sync3Q <= sync2Q;
         filtQ <= filtD;
      end
   end

   // event decode; hold freezes everything except the output enable, which it clears
   assign csFallEv = filtQ.holdN && filtQ.csN && !filtD.csN;
   assign csRiseEv = filtQ.holdN && !filtQ.csN && filtD.csN;
   assign active = csActQ && filtQ.holdN && !csRiseEv;
   // edges only, no timeout: the host may park the clock for any time
   assign riseEv = active && !filtQ.sck && filtD.sck;
   assign fallEv = active && riseSeenQ && filtQ.sck && !filtD.sck;
   assign byteDone = riseEv && (bitCntQ == `SSM_BYTE_LAST);
   assign inByte = {shiftQ, filtQ.si};
   assign memAddr = addrQ[ADDR_W-1:0];
   assign rdByte = (cmdQ == `SSM_CMD_ST_RD) ? statusQ : memQ[memAddr];
   assign memWe = byteDone && stateQ == ssm_pkg::ST_WDATA && statusQ[`SSM_ST_WEL]
      && !guarded(statusQ[`SSM_ST_GUARD_HI -: 2], memAddr);
   assign stWrOk = statusQ[`SSM_ST_WEL]
      && (!statusQ[`SSM_ST_LOCK] || filtQ.wpN);

   // select tracking and mode capture
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         csActQ <= 1'b0;
         spiModeQ <= 1'b0;
         riseSeenQ <= 1'b0;
      end else begin
         if (csFallEv) begin
            csActQ <= 1'b1;
            spiModeQ <= filtQ.sck;
            riseSeenQ <= 1'b0;
         end else if (csRiseEv) begin
            csActQ <= 1'b0;
         end else if (riseEv) begin
            riseSeenQ <= 1'b1;
         end
      end
   end

   // input shifter, msb first
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bitCntQ <= 3'h0;
         shiftQ <= 7'h00;
      end else if (csFallEv) begin
         bitCntQ <= 3'h0;
      end else if (riseEv) begin
         bitCntQ <= bitCntQ + 3'h1;
         shiftQ <= inByte[6:0];
      end
   end

   // command decode and sequencing
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stateQ <= ssm_pkg::ST_IDLE;
         cmdQ <= 8'h00;
         addrCntQ <= 2'h0;
         addrQ <= 16'h0000;
         statusQ <= `SSM_ST_RESET;
         sleepQ <= 1'b0;
      end else if (csFallEv) begin
         stateQ <= ssm_pkg::ST_CMD;
         addrCntQ <= 2'h0;
      end else if (csRiseEv) begin
         stateQ <= ssm_pkg::ST_IDLE;
      end else if (fallEv && stateQ == ssm_pkg::ST_RDOUT && outCntQ == 3'h0
            && cmdQ == `SSM_CMD_ARR_RD) begin
         addrQ <= {1'b0, memAddr + 1'b1};
      end else if (byteDone) begin
         unique case (stateQ)
            ssm_pkg::ST_CMD: begin
               cmdQ <= inByte;
               stateQ <= ssm_pkg::ST_DONE;
               if (sleepQ) begin
                  // only wake is obeyed while asleep
                  if (inByte == `SSM_CMD_WAKE) sleepQ <= 1'b0;
               end else begin
                  case (inByte)
                     `SSM_CMD_SET_WL: statusQ[`SSM_ST_WEL] <= 1'b1;
                     `SSM_CMD_CLR_WL: statusQ[`SSM_ST_WEL] <= 1'b0;
                     `SSM_CMD_ST_RD: stateQ <= ssm_pkg::ST_RDOUT;
                     `SSM_CMD_ST_WR: stateQ <= ssm_pkg::ST_STWR;
                     `SSM_CMD_ARR_RD: stateQ <= ssm_pkg::ST_ADDR;
                     `SSM_CMD_ARR_WR: stateQ <= ssm_pkg::ST_ADDR;
                     `SSM_CMD_SLEEP: sleepQ <= 1'b1;
                     default: stateQ <= ssm_pkg::ST_DONE; // unknown or wake: nothing
                  endcase
               end
            end
            ssm_pkg::ST_ADDR: begin
               // high byte first
               addrQ <= {addrQ[7:0], inByte};
               addrCntQ <= addrCntQ + 2'h1;
               if (addrCntQ + 2'h1 == `SSM_ADDR_BYTES) begin
                  stateQ <= (cmdQ == `SSM_CMD_ARR_RD) ? ssm_pkg::ST_RDOUT
                     : ssm_pkg::ST_WDATA;
               end
            end
            ssm_pkg::ST_WDATA: begin
               addrQ <= {1'b0, memAddr + 1'b1};
            end
            ssm_pkg::ST_STWR: begin
               // latch bit keeps its value; others replaced
               if (stWrOk) begin
                  statusQ <= {inByte[7:2], statusQ[`SSM_ST_WEL], inByte[0]};
               end
               stateQ <= ssm_pkg::ST_DONE;
            end
            ssm_pkg::ST_RDOUT, ssm_pkg::ST_DONE, ssm_pkg::ST_IDLE: begin
               stateQ <= stateQ;
            end
            default: stateQ <= ssm_pkg::ST_DONE;
         endcase
      end
   end

   // array write port
   always_ff @(posedge ref_clk) begin
      if (memWe) begin
         memQ[memAddr] <= inByte;
      end
   end

   // serial output, changes on falling edges only
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         serOutQ <= 1'b0;
         serOutEnQ <= 1'b0;
         outShiftQ <= 7'h00;
         outCntQ <= 3'h0;
      end else begin
         if (!csActQ || !filtQ.holdN || csRiseEv || stateQ != ssm_pkg::ST_RDOUT) begin
            serOutEnQ <= 1'b0;
         end else if (fallEv) begin
            serOutEnQ <= 1'b1;
         end
         if (stateQ != ssm_pkg::ST_RDOUT) begin
            outCntQ <= 3'h0;
         end else if (fallEv) begin
            outCntQ <= outCntQ + 3'h1;
            if (outCntQ == 3'h0) begin
               serOutQ <= rdByte[7];
               outShiftQ <= rdByte[6:0];
            end else begin
               serOutQ <= outShiftQ[6];
               outShiftQ <= {outShiftQ[5:0], 1'b0};
            end
         end
      end
   end

   // checks
   property p_cs_high_quiet;
      @(posedge ref_clk) disable iff (rst) !csActQ |=> !serOutEnQ;
   endproperty
   a_cs_high_quiet: assert property (p_cs_high_quiet) else $error("output on while deselected");
   property p_hold_quiet;
      @(posedge ref_clk) disable iff (rst) !filtQ.holdN |=> !serOutEnQ;
   endproperty
   a_hold_quiet: assert property (p_hold_quiet) else $error("output on during hold");
   property p_out_on_fall;
      @(posedge ref_clk) disable iff (rst) $changed(serOutQ) |-> $past(fallEv);
   endproperty
   a_out_on_fall: assert property (p_out_on_fall) else $error("output moved off falling edge");
   property p_hold_freeze;
      @(posedge ref_clk) disable iff (rst) !filtQ.holdN |=> $stable(bitCntQ) && $stable(stateQ);
   endproperty
   a_hold_freeze: assert property (p_hold_freeze) else $error("state moved during hold");
   property p_set_latch;
      @(posedge ref_clk) disable iff (rst)
         byteDone && stateQ == ssm_pkg::ST_CMD && !sleepQ && inByte == `SSM_CMD_SET_WL
         |=> statusQ[`SSM_ST_WEL] ##1 stateQ != ssm_pkg::ST_CMD;
   endproperty
   a_set_latch: assert property (p_set_latch) else $error("latch not set");
   property p_write_gate;
      @(posedge ref_clk) disable iff (rst)
         memWe |-> statusQ[`SSM_ST_WEL]
            && !(statusQ[`SSM_ST_GUARD_HI] && statusQ[`SSM_ST_GUARD_LO])
            && !(statusQ[`SSM_ST_GUARD_HI] && memAddr[ADDR_W-1])
            && !(statusQ[`SSM_ST_GUARD_LO] && memAddr[ADDR_W-1] && memAddr[ADDR_W-2]);
   endproperty
   a_write_gate: assert property (p_write_gate) else $error("write into protected area");
   property p_lock_hold;
      @(posedge ref_clk) disable iff (rst)
         byteDone && stateQ == ssm_pkg::ST_STWR && statusQ[`SSM_ST_LOCK] && !filtQ.wpN
         |=> statusQ == $past(statusQ);
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("locked status changed");
   property p_sleep_stays;
      @(posedge ref_clk) disable iff (rst)
         sleepQ && byteDone && stateQ == ssm_pkg::ST_CMD && inByte != `SSM_CMD_WAKE
         |=> sleepQ && $stable(statusQ);
   endproperty
   a_sleep_stays: assert property (p_sleep_stays) else $error("command obeyed asleep");
   property p_one_cmd;
      @(posedge ref_clk) disable iff (rst)
         stateQ == ssm_pkg::ST_DONE && !csFallEv |=> stateQ inside {ssm_pkg::ST_DONE, ssm_pkg::ST_IDLE};
   endproperty
   a_one_cmd: assert property (p_one_cmd) else $error("second command in one select");
   property p_wrap;
      @(posedge ref_clk) disable iff (rst) memWe && &memAddr |=> memAddr == '0;
   endproperty
   a_wrap: assert property (p_wrap) else $error("address did not wrap");
   c_array_write: cover property (@(posedge ref_clk) disable iff (rst) memWe);
   c_read_drive: cover property (@(posedge ref_clk) disable iff (rst) serOutEnQ && cmdQ == `SSM_CMD_ARR_RD);
   c_status_write: cover property (@(posedge ref_clk) disable iff (rst)
      byteDone && stateQ == ssm_pkg::ST_STWR && stWrOk);
   c_mode3: cover property (@(posedge ref_clk) disable iff (rst) spiModeQ && riseEv);
endmodule

/* File: test/ssm_host_model.sv */
// behavioural serial host that drives the pins of the memory front end
`timescale 1ns/1ns
module ssm_host_model (
   // system clock used as time base
   input wire logic ref_clk,
   // serial output wire as seen on the board
   input wire logic soWire,
   // pins toward the target
   output logic spiClk,
   output logic chipSelN,
   output logic serIn,
   output logic holdN
);
   // pins idle, target deselected
   initial begin
      spiClk = 1'b0;
      chipSelN = 1'b1;
      serIn = 1'b0;
      holdN = 1'b1;
   end
   // wait a number of system clock edges
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // park the clock at the mode level, then select
   task automatic open(input logic mode);
      spiClk <= mode;
      tick(8);
      chipSelN <= 1'b0;
      tick(8);
   endtask
   // one byte each way: data moves after the fall, both sides take it at the rise
   // periods of 120 and 130 ns alternate, 125 ns on average, one byte per microsecond
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         spiClk <= 1'b0;
         serIn <= tx[i];
         tick(6);
         rx[i] = soWire;
         spiClk <= 1'b1;
         tick(6 + i % 2);
      end
   endtask
   // deselect on a byte boundary; the data line is inverted and stops showing its bit
   task automatic close(input logic mode);
      spiClk <= mode;
      serIn <= ~serIn;
      tick(8);
      chipSelN <= 1'b1;
      tick(8);
   endtask
   // move hold while selected; while low, clock pulses must be ignored
   task automatic hold(input logic v);
      holdN <= v;
      tick(8);
      if (!v) begin
         repeat (2) begin
            spiClk <= 1'b0;
            tick(7);
            spiClk <= 1'b1;
            tick(7);
         end
      end
   endtask
endmodule

/* File: test/tb.sv */
// self-checking bench for the serial memory front end
`timescale 1ns/1ns
`include "ssm_cfg.svh"
module tb;
   // clock, reset and the pins owned by the bench
   logic ref_clk, rst, writeProtN;
   // pins driven by the host model
   wire spiClk, chipSelN, serIn, holdN;
   // target outputs and the resolved output wire
   logic serOutQ, serOutEnQ, spiModeQ, sleepQ;
   wire soWire = serOutEnQ ? serOutQ : 1'bz;
   // result bookkeeping
   int badCount = 0;
   int samplesChecked = 0;
   logic [39:0] rx;
   logic [7:0] r;
   logic [15:0] adr[3] = '{16'h0000, 16'h4000, 16'h6000};
   logic [7:0] mem[3];
   ssm_front_end dut (.ref_clk(ref_clk), .rst(rst), .spiClk(spiClk),
      .chipSelN(chipSelN), .serIn(serIn), .holdN(holdN), .writeProtN(writeProtN),
      .serOutQ(serOutQ), .serOutEnQ(serOutEnQ), .spiModeQ(spiModeQ), .sleepQ(sleepQ));
   ssm_host_model host (.ref_clk(ref_clk), .soWire(soWire), .spiClk(spiClk),
      .chipSelN(chipSelN), .serIn(serIn), .holdN(holdN));
   // 100 MHz system clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // compare and count
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         badCount++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // one select period of n bytes, msb byte of tx first
   task automatic frame(input logic m, input int n, input logic [39:0] tx);
      rx = '0;
      host.open(m);
      for (int k = 0; k < n; k++) begin
         host.xfer(tx[39-8*k -: 8], r);
         rx[39-8*k -: 8] = r;
      end
      host.close(m);
   endtask
   // short helpers for single commands and accesses
   task automatic cmd(input logic [7:0] c);
      frame(1'b0, 1, {c, 32'h0});
   endtask
   task automatic wrst(input logic [7:0] v);
      cmd(`SSM_CMD_SET_WL);
      frame(1'b0, 2, {`SSM_CMD_ST_WR, v, 24'h0});
   endtask
   task automatic rdst(input logic [7:0] e);
      frame(1'b0, 3, {`SSM_CMD_ST_RD, 32'h0});
      check(rx[31:24], e);
      check({7'h0, serOutEnQ}, 8'h00);
   endtask
   task automatic wrarr(input logic [15:0] a, input logic [7:0] d);
      cmd(`SSM_CMD_SET_WL);
      frame(1'b0, 4, {`SSM_CMD_ARR_WR, a, d, 8'h0});
   endtask
   // ends the run with the verdict
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", samplesChecked, badCount);
      if (badCount == 0 && samplesChecked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // latch commands, the status layout, one command per select
   task automatic t_latch();
      rdst(8'h00);
      cmd(`SSM_CMD_SET_WL);
      rdst(8'h02);
      cmd(`SSM_CMD_CLR_WL);
      rdst(8'h00);
      frame(1'b0, 2, {`SSM_CMD_SET_WL, `SSM_CMD_CLR_WL, 24'h0});
      rdst(8'h02);
      $display("test latch done");
   endtask
   // mode 3 burst across the top, address bit 15 ignored
   task automatic t_burst();
      cmd(`SSM_CMD_SET_WL);
      frame(1'b1, 5, {`SSM_CMD_ARR_WR, 16'hFFFF, 16'hA53C});
      check({7'h0, spiModeQ}, 8'h01);
      frame(1'b1, 5, {`SSM_CMD_ARR_RD, 16'h7FFF, 16'h0});
      check(rx[15:8], 8'hA5);
      check(rx[7:0], 8'h3C);
      frame(1'b0, 4, {`SSM_CMD_ARR_RD, 16'h0000, 16'h0});
      check(rx[15:8], 8'h3C);
      check({7'h0, spiModeQ}, 8'h00);
      $display("test burst done");
   endtask
   // cleared latch drops writes; each guard pair protects its region
   task automatic t_guard();
      for (int k = 0; k < 3; k++) begin
         wrarr(adr[k], 8'h11);
         mem[k] = 8'h11;
      end
      cmd(`SSM_CMD_CLR_WL);
      frame(1'b0, 4, {`SSM_CMD_ARR_WR, adr[0], 16'h5500});
      frame(1'b0, 4, {`SSM_CMD_ARR_RD, adr[0], 16'h0});
      check(rx[15:8], 8'h11);
      writeProtN <= 1'b0;
      for (int g = 0; g < 4; g++) begin
         wrst(8'(g * 4));
         rdst(8'(g * 4 + 2));
         for (int k = 0; k < 3; k++) begin
            wrarr(adr[k], 8'(g * 16 + k));
            if (!(g == 3 || (g == 2 && k > 0) || (g == 1 && k == 2))) begin
               mem[k] = 8'(g * 16 + k);
            end
         end
         for (int k = 0; k < 3; k++) begin
            frame(1'b0, 4, {`SSM_CMD_ARR_RD, adr[k], 16'h0});
            check(rx[15:8], mem[k]);
         end
      end
      $display("test guard done");
   endtask
   // lock bit honours the write-protect pin
   task automatic t_lock();
      writeProtN <= 1'b1;
      wrst(8'h80);
      rdst(8'h82);
      writeProtN <= 1'b0;
      wrst(8'h00);
      rdst(8'h82);
      writeProtN <= 1'b1;
      // unlocks and sets the bits that have no effect on operation
      wrst(8'h71);
      rdst(8'h73);
      $display("test lock done");
   endtask
   // hold suspends a status read, sleep gates a status read until wake
   task automatic t_hold_sleep();
      host.open(1'b0);
      host.xfer(`SSM_CMD_ST_RD, r);
      host.hold(1'b0);
      check({7'h0, serOutEnQ}, 8'h00);
      host.hold(1'b1);
      host.xfer(8'h00, r);
      host.close(1'b0);
      check(r, 8'h73);
      cmd(`SSM_CMD_SLEEP);
      check({7'h0, sleepQ}, 8'h01);
      frame(1'b0, 2, {`SSM_CMD_ST_RD, 32'h0});
      check(rx[31:24], 8'hzz);
      cmd(`SSM_CMD_WAKE);
      check({7'h0, sleepQ}, 8'h00);
      rdst(8'h73);
      $display("test hold and sleep done");
   endtask
   // main sequence
   initial begin
      rst = 1'b1;
      writeProtN = 1'b1;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      host.tick(8);
      t_latch();
      t_burst();
      t_guard();
      t_lock();
      t_hold_sleep();
      give_verdict();
   end
   // cut a hang short
   initial begin
      #900000;
      badCount++;
      give_verdict();
   end
endmodule
